// ---- design/sram_rd_defs.svh ----
`ifndef SRAM_RD_DEFS_SVH
`define SRAM_RD_DEFS_SVH
// Clock period in picoseconds
`define CLK_PERIOD_PS 8000
// Read timing figures in nanoseconds
`define READ_CYCLE_TIME_NS 20
`define ADDR_ACCESS_TIME_NS 20
`define OUT_HOLD_TIME_NS 3
`define OE_ACCESS_TIME_NS 10
`define OE_RELEASE_TIME_NS 10
`define CE_ACCESS_TIME_NS 20
`define CE_RELEASE_TIME_NS 10
`define ADDR_SKEW_TIME_NS 4
// Least times round up to whole cycles
`define CYC_UP(ns) (((ns) * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define READ_CYCLE_CYC `CYC_UP(`READ_CYCLE_TIME_NS)
`define ACCESS_CYC `CYC_UP(`ADDR_ACCESS_TIME_NS)
`define RELEASE_CYC `CYC_UP(`CE_RELEASE_TIME_NS)
`define CNT_W 4
`endif

// ---- design/sram_rd_pkg.sv ----
package sram_rd_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_DONE = 2'b10,
        ST_GAP = 2'b11
    } rd_state_type;
endpackage

// ---- design/rd_wait_timer.sv ----
`timescale 1ns/1ps
`include "sram_rd_defs.svh"
// Down counter: load a count, flag when it reaches zero
module rd_wait_timer #(
    parameter int W = `CNT_W
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic load,
    input wire logic [W-1:0] count,
    output logic expired
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } tmr_state_type;
    tmr_state_type s_q, s_d;

    // Next count
    always_comb begin
        s_d = s_q;
        if (load) begin
            s_d.cnt = count;
        end else if (s_q.cnt != '0) begin
            s_d.cnt = s_q.cnt - 1'b1;
        end
    end

    // Register
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign expired = (s_q.cnt == '0) && !load;
endmodule

// ---- design/sram_rd_ctrl.sv ----
// Contract
// - Read holds write-enable high and chip-enable low throughout.
// - Address changes no faster than one per 20 ns read cycle.
// - Early address change is invalid; re-initialize before further reads.
// - All address bits settle within 4 ns of each other.
// - Address valid no later than 4 ns after chip-enable falls.
`timescale 1ns/1ps
`include "sram_rd_defs.svh"
module sram_rd_ctrl #(
    parameter int ADDR_W = 19,
    parameter int DATA_W = 8,
    parameter int N_CE = 1
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic req_valid,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [$clog2(N_CE+1)-1:0] req_die,
    output logic req_ready,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_data,
    output logic [ADDR_W-1:0] mem_addr,
    output logic [N_CE-1:0] mem_ce_n,
    output logic mem_oe_n,
    output logic mem_we_n,
    input wire logic [DATA_W-1:0] mem_dq
);
    import sram_rd_pkg::*;

    // Die index width, as the request port carries it
    localparam int DIE_W = $clog2(N_CE + 1);
    // Wait lengths in clock cycles, each rounded up so no least time is cut
    localparam int ACCESS_CYC = `ACCESS_CYC;
    localparam int CYCLE_CYC = `READ_CYCLE_CYC;
    localparam int GAP_CYC = `RELEASE_CYC;

    typedef struct packed {
        rd_state_type st;
        logic [ADDR_W-1:0] addr;
        logic [N_CE-1:0] ce_n;
        logic oe_n;
        logic [DATA_W-1:0] data;
        logic rsp;
        logic [`CNT_W-1:0] age; // Cycles since the last address launch
    } ctrl_state_type;

    // Quiet bus after reset; the launch guard starts satisfied
    localparam ctrl_state_type CTRL_IDLE = '{
        st: ST_IDLE,
        addr: '0,
        ce_n: '1,
        oe_n: 1'b1,
        data: '0,
        rsp: 1'b0,
        age: `CNT_W'(CYCLE_CYC)
    };

    ctrl_state_type s_q, s_d;
    logic tmr_load;
    logic [`CNT_W-1:0] tmr_count;
    logic tmr_done;
    logic [N_CE-1:0] sel_ce_n;
    logic sel_ok;
    logic launch_ok;

    // True when the index names a fitted die
    function automatic logic die_valid(input logic [DIE_W-1:0] die);
        die_valid = 1'b0;
        for (int i = 0; i < N_CE; i++) begin
            if (die == i[DIE_W-1:0]) begin
                die_valid = 1'b1;
            end
        end
    endfunction

    // One-hot chip-enable select; decoded for every new read
    function automatic logic [N_CE-1:0] ce_select(input logic [DIE_W-1:0] die);
        ce_select = '1;
        for (int i = 0; i < N_CE; i++) begin
            if (die == i[DIE_W-1:0]) begin
                ce_select[i] = 1'b0;
            end
        end
    endfunction

    // Timer load for a wait; the timer adds one cycle of its own, so each wait
    // runs a cycle longer than its figure, trading a little speed for margin
    function automatic logic [`CNT_W-1:0] wait_load(input int cycles);
        wait_load = `CNT_W'(cycles);
    endfunction

    // Shared timer covers the access wait and the release gap
    rd_wait_timer #(.W(`CNT_W)) u_timer (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .load(tmr_load),
        .count(tmr_count),
        .expired(tmr_done)
    );

    // Request decode: which pin to pull low, and whether any die answers
    assign sel_ce_n = ce_select(req_die);
    assign sel_ok = die_valid(req_die);

    // A launch waits a full read cycle after the previous one, whatever the
    // wait lengths; moving the address sooner would spoil the read
    assign launch_ok = (s_q.age >= `CNT_W'(CYCLE_CYC));

    // Ready only in idle, so address never moves inside a read cycle
    assign req_ready = (s_q.st == ST_IDLE) && launch_ok;

    // Control sequence
    always_comb begin
        s_d = s_q;
        s_d.rsp = 1'b0;
        tmr_load = 1'b0;
        tmr_count = '0;
        // Launch age saturates once the guard is met
        if (s_q.age < `CNT_W'(CYCLE_CYC)) begin
            s_d.age = s_q.age + 1'b1;
        end
        unique case (s_q.st)
            ST_IDLE: begin
                if (req_valid && launch_ok) begin
                    // Address and enables launch on the same edge from flops,
                    // so skew and setup stay within one register delay
                    s_d.addr = req_addr;
                    s_d.ce_n = sel_ce_n;
                    // An index with no die keeps output-enable high too, so
                    // output-enable never falls without a chip-enable
                    s_d.oe_n = !sel_ok;
                    s_d.age = '0;
                    tmr_load = 1'b1;
                    // Sample only once the access time has run out
                    tmr_count = wait_load(ACCESS_CYC);
                    s_d.st = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (tmr_done) begin
                    // With no die selected nothing drives the pins; return zero
                    s_d.data = (&s_q.ce_n) ? '0 : mem_dq;
                    s_d.st = ST_DONE;
                end
            end
            ST_DONE: begin
                // Deassert enables; leave the bus idle long enough to release
                s_d.ce_n = '1;
                s_d.oe_n = 1'b1;
                s_d.rsp = 1'b1;
                tmr_load = 1'b1;
                tmr_count = wait_load(GAP_CYC);
                s_d.st = ST_GAP;
            end
            ST_GAP: begin
                // Fresh chip-enable read each time avoids any invalid cycle
                if (tmr_done) begin
                    s_d.st = ST_IDLE;
                end
            end
        endcase
    end

    // Register all state
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            s_q <= CTRL_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // Pins and answer come straight from flops, except write-enable, which is tied high
    assign mem_addr = s_q.addr;
    assign mem_ce_n = s_q.ce_n;
    assign mem_oe_n = s_q.oe_n;
    assign mem_we_n = 1'b1;
    assign rsp_valid = s_q.rsp;
    assign rsp_data = s_q.data;
endmodule

// ---- bench/sram_rd_props.sv ----
`timescale 1ns/1ps
module sram_rd_props #(parameter int ADDR_W = 19, parameter int DATA_W = 8,
    parameter int N_CE = 1) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic req_valid,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [$clog2(N_CE+1)-1:0] req_die,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic [DATA_W-1:0] rsp_data,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic [N_CE-1:0] mem_ce_n,
    input wire logic mem_oe_n,
    input wire logic mem_we_n,
    input wire logic [DATA_W-1:0] mem_dq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_we_high: assert property (mem_we_n) else $error("we low");
    a_read_frame: assert property (req_valid && req_ready |=> (!mem_ce_n[0] &&
        !mem_oe_n)[*5] ##1 (rsp_valid && mem_ce_n[0] && mem_oe_n)) else $error("frame");
    a_addr_taken: assert property (req_valid && req_ready |=>
        mem_addr == $past(req_addr)) else $error("addr");
    a_addr_steady: assert property (!mem_ce_n[0] |=> mem_ce_n[0] ||
        $stable(mem_addr)) else $error("addr moved");
    a_rsp_data: assert property (rsp_valid |-> rsp_data == $past(mem_dq))
        else $error("data");
    a_release_gap: assert property (rsp_valid |-> !req_ready[*3] ##1 req_ready)
        else $error("gap");
    a_rsp_spacing: assert property (rsp_valid |=> !rsp_valid[*6]) else $error("rsp");
    a_oe_under_ce: assert property (!mem_oe_n |-> !mem_ce_n[0]) else $error("oe");
endmodule
bind sram_rd_ctrl sram_rd_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .N_CE(N_CE)) u_props (.*);

// ---- bench/sram_model.sv ----
`timescale 1ns/1ps
// Memory read side; data is a fixed mix of the address
module sram_model (
    input wire logic [18:0] addr,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    output logic [7:0] dq
);
    initial dq = 8'h00;
    // Old data turns to junk after hold time, so late sampling is caught
    always @(addr, ce_n, oe_n, we_n) begin
        dq <= #3 ~dq;
        if (!ce_n && !oe_n && we_n) dq <= #20 addr[7:0] ^ 8'h5A;
    end
endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    logic clk_sys = 0, reset_n = 0, req_valid = 0;
    logic [18:0] req_addr = '0, mem_addr;
    logic [0:0] req_die = '0, mem_ce_n;
    logic req_ready, rsp_valid, mem_oe_n, mem_we_n;
    logic [7:0] rsp_data, mem_dq;
    int errors = 0, checks_done = 0;
    sram_rd_ctrl dut (.*);
    sram_model mem (.addr(mem_addr), .ce_n(mem_ce_n[0]), .oe_n(mem_oe_n), .we_n(mem_we_n),
        .dq(mem_dq));
    initial forever #4 clk_sys = ~clk_sys;
    task automatic print_verdict;
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input bit ok, input string msg);
        checks_done++;
        if (!ok) begin
            errors++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // One read; latency and data judged, bounded waits
    task automatic read_word(input logic [18:0] a);
        int n;
        req_valid = 1;
        req_addr = a;
        for (n = 0; n < 20 && !req_ready; n++) step(1);
        chk(n < 20, "never ready");
        if (n == 20) print_verdict();
        step(1);
        req_valid = 0;
        for (n = 0; n < 20 && !rsp_valid; n++) step(1);
        chk(n == 5, "latency");
        chk(rsp_data === (a[7:0] ^ 8'h5A), "data");
        if (n == 20) print_verdict();
    endtask
    // Reset in mid-read must drop both enables
    task automatic abort_read;
        int n;
        req_valid = 1;
        req_addr = 19'h12345;
        for (n = 0; n < 20 && !req_ready; n++) step(1);
        chk(n < 20, "never ready");
        if (n == 20) print_verdict();
        step(2);
        chk(mem_ce_n === 1'b0 && mem_oe_n === 1'b0, "not in read");
        chk(mem_addr === 19'h12345, "addr");
        reset_n = 0;
        req_valid = 0;
        step(1);
        chk(mem_ce_n === 1'b1 && mem_oe_n === 1'b1 && rsp_valid === 1'b0, "abort");
        reset_n = 1;
    endtask
    initial begin
        step(10);
        chk(mem_ce_n === 1'b1 && mem_oe_n === 1'b1 && mem_we_n === 1'b1, "reset");
        reset_n = 1;
        read_word(19'h00000);
        read_word(19'h7FFFF);
        read_word(19'h55555);
        abort_read();
        read_word(19'h2AAAA);
        print_verdict();
    end
endmodule
